//--- rtl/seq_ctrl.v
// Frame-based channel sequencing control with serial register writes
//
// Operation
// R1: Writing the manual register selects manual mode, each frame choosing the next source.
// R2: The manual channel field picks channel 0 to 3, sampled in frame n+1, result in frame n+2.
// R3: The host writes zero to manual bit 7 and auto bits 6..4; manual bit 4 is ignored.
// R4: The range field of either register applies only to the next frame, nonzero overriding.
// R5: Range codes 000 keep, 001/010/011/101/110 select ranges, 100 is never written.
// R6: Range code 111 powers the device down right after the sixteenth falling clock edge.
// R7: Manual bit 0 samples the temperature sensor next frame and ignores the range.
// R8: Writing the auto register selects auto-scan, one new channel per frame.
// R9: Auto bit 7 resets the sequence so the next frame samples the lowest enabled channel.
// R10: Auto bit 0 samples the sensor next frame, then resumes with the pending channel.
// R11: An all-zero frame continues in the last selected manual or auto mode.
// R12: Continued frames use the configured per-channel ranges with no override.
// R13: Continued frames keep sampling the sensor if it was selected last.
// R14: Page 0 is active after reset; writing 01h to the page address selects page 1.
// R15: Auto-scan visits only enabled channels ascending, wrapping to the lowest; the code samples channel 0 when no channel is enabled.
// R16: A frame is 16 clocks under chip select: 7-bit address, write flag, 8 data bits.
`include "seq_ctrl_defines.vh"
module seq_ctrl #(
    parameter NCH = 4
) (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Serial link pins
    input wire sclk,
    input wire cs_n,
    input wire din,
    // Conversion control for the current frame
    output reg [1:0] sample_ch_r,
    output reg sample_temp_r,
    output reg [2:0] sample_range_r,
    output reg power_down_r,
    output reg frame_start_r,
    output reg mode_r,
    output reg page_r,
    output reg [1:0] result_ch_r
);
    wire sclk_s;
    wire cs_n_s;
    wire din_s;
    link_sync u_sclk (.clock(clock), .sys_rst(sys_rst), .din(sclk), .dout(sclk_s));
    link_sync #(.RST_VAL(1'b1)) u_cs (.clock(clock), .sys_rst(sys_rst), .din(cs_n),
        .dout(cs_n_s));
    link_sync u_din (.clock(clock), .sys_rst(sys_rst), .din(din), .dout(din_s));

    reg sclk_d_r;
    reg cs_d_r;
    reg [15:0] shift_r;
    reg [4:0] count_r;
    reg [7:0] mask_r;
    reg [2:0] cfg_range_r [0:NCH-1];
    reg temp_sel_r;
    reg [1:0] cur_ch_r;
    reg mode_nxt;
    reg temp_sel_nxt;
    reg sample_temp_nxt;
    reg [1:0] sample_ch_nxt;
    reg [2:0] ovr_nxt;
    reg [2:0] sample_range_nxt;
    reg [1:0] cur_ch_nxt;
    integer i;
    localparam integer CFG_END_I = `ADDR_CFG_BASE + NCH;
    localparam [6:0] CFG_END = CFG_END_I[6:0];

    wire rise = sclk_s & ~sclk_d_r;
    wire fall = ~sclk_s & sclk_d_r;
    wire cs_act = ~cs_n_s;
    wire frame_end = cs_n_s & ~cs_d_r;
    wire [15:0] word = shift_r;
    wire [6:0] w_addr = word[15:9];
    wire w_wr = word[8];
    wire [7:0] w_data = word[7:0];
    wire full = (count_r == `FRAME_BITS);
    wire is_man = full && !w_wr && !page_r && (w_addr == `ADDR_MANUAL);
    wire is_auto = full && !w_wr && !page_r && (w_addr == `ADDR_AUTO);
    wire is_cfg = (w_addr >= `ADDR_CFG_BASE) && (w_addr < CFG_END);

    // Enabled-channel bit for a channel number (channel k at mask bit 7-2k)
    function ch_en;
        input [7:0] m;
        input [1:0] c;
        begin
            ch_en = m[3'h7 - {c, 1'b0}];
        end
    endfunction

    // Next enabled channel after c, wrapping; channel 0 when none enabled
    function [1:0] next_en;
        input [7:0] m;
        input [1:0] c;
        reg [1:0] k;
        reg found;
        integer j;
        begin
            next_en = 2'h0;
            found = 1'b0;
            for (j = 1; j <= 4; j = j + 1) begin
                k = c + j[1:0];
                if (!found && ch_en(m, k)) begin
                    next_en = k;
                    found = 1'b1;
                end
            end
        end
    endfunction

    // Lowest enabled channel
    function [1:0] low_en;
        input [7:0] m;
        begin
            low_en = next_en(m, 2'h3);
        end
    endfunction

    // Selection launched when the current frame ends
    always @* begin
        mode_nxt = mode_r;
        temp_sel_nxt = temp_sel_r;
        sample_temp_nxt = temp_sel_r; // [R13]
        sample_ch_nxt = cur_ch_r;
        ovr_nxt = `RANGE_KEEP; // [R12]
        if (is_man) begin
            mode_nxt = `MODE_MANUAL; // [R1]
            temp_sel_nxt = w_data[0];
            sample_temp_nxt = w_data[0]; // [R7]
            if (!w_data[0]) begin
                sample_ch_nxt = w_data[6:5]; // [R2] [R3]
            end
        end else if (is_auto) begin
            mode_nxt = `MODE_AUTO; // [R8]
            temp_sel_nxt = w_data[0];
            sample_temp_nxt = w_data[0]; // [R10]
            if (!w_data[0] && w_data[7]) begin
                sample_ch_nxt = low_en(mask_r); // [R9]
            end else if (!w_data[0]) begin
                sample_ch_nxt = next_en(mask_r, cur_ch_r); // [R15]
            end
        end else if (mode_r == `MODE_AUTO && !temp_sel_r) begin
            // Any other frame continues in the last mode [R11]
            sample_ch_nxt = next_en(mask_r, cur_ch_r); // [R15]
        end
        if ((is_man || is_auto) && !w_data[0] && w_data[3:1] != `RANGE_PDOWN) begin
            ovr_nxt = w_data[3:1]; // [R4] [R5]
        end
        sample_range_nxt = sample_temp_nxt ? `RANGE_KEEP :
            (ovr_nxt != `RANGE_KEEP ? ovr_nxt : cfg_range_r[sample_ch_nxt]);
        cur_ch_nxt = cur_ch_r;
        if (!sample_temp_nxt) begin
            cur_ch_nxt = sample_ch_nxt;
        end else if (is_auto && w_data[7]) begin
            // Park the counter so the scan restarts at the lowest channel [R9]
            cur_ch_nxt = 2'h3;
        end
    end

    // Serial shift and frame decode
    always @(posedge clock) begin
        if (sys_rst) begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            shift_r <= 16'h0000;
            count_r <= 5'h00;
            mask_r <= `MASK_RESET;
            for (i = 0; i < NCH; i = i + 1) begin
                cfg_range_r[i] <= `CFG_RESET;
            end
            mode_r <= `MODE_MANUAL;
            page_r <= 1'b0;
            temp_sel_r <= 1'b0;
            cur_ch_r <= 2'h0;
            sample_ch_r <= 2'h0;
            sample_temp_r <= 1'b0;
            sample_range_r <= `RANGE_KEEP;
            power_down_r <= 1'b0;
            frame_start_r <= 1'b0;
            result_ch_r <= 2'h0;
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_n_s;
            frame_start_r <= 1'b0;
            if (cs_act && rise && !full) begin // [R16]
                shift_r <= {shift_r[14:0], din_s};
                count_r <= count_r + 5'h01;
            end
            // Power down right after the 16th falling edge [R6]
            if (cs_act && fall && full && !w_wr && !page_r &&
                (w_addr == `ADDR_MANUAL || w_addr == `ADDR_AUTO) &&
                w_data[3:1] == `RANGE_PDOWN && !w_data[0]) begin
                power_down_r <= 1'b1;
            end
            if (cs_act && !cs_d_r && cs_n_s == 1'b0 && count_r == 5'h00 && power_down_r) begin
                power_down_r <= 1'b0;
            end
            if (frame_end) begin
                count_r <= 5'h00;
                shift_r <= 16'h0000;
                // Launch the selection that the ending frame wrote
                frame_start_r <= 1'b1;
                sample_ch_r <= sample_ch_nxt; // [R2]
                sample_temp_r <= sample_temp_nxt; // [R7] [R13]
                sample_range_r <= sample_range_nxt; // [R4] [R12]
                result_ch_r <= sample_ch_r; // [R2]
                mode_r <= mode_nxt; // [R1] [R8]
                temp_sel_r <= temp_sel_nxt;
                cur_ch_r <= cur_ch_nxt; // [R10]
                if (full && !w_wr) begin
                    if (w_addr == `ADDR_PAGE) begin
                        page_r <= (w_data == `PAGE1_VALUE); // [R14]
                    end else if (!page_r && w_addr == `ADDR_CH_MASK) begin
                        mask_r <= w_data; // [R15]
                    end else if (!page_r && is_cfg) begin
                        cfg_range_r[w_addr[1:0]] <= w_data[2:0]; // [R12]
                    end
                end
            end
        end
    end
endmodule

//--- rtl/seq_ctrl_defines.vh
// Constants for the channel sequencing control block
`ifndef SEQ_CTRL_DEFINES_VH
`define SEQ_CTRL_DEFINES_VH
`define ADDR_MANUAL 7'h04
`define ADDR_AUTO 7'h05
`define ADDR_CH_MASK 7'h0c
`define ADDR_CFG_BASE 7'h10
`define ADDR_PAGE 7'h7f
`define PAGE1_VALUE 8'h01
`define RANGE_KEEP 3'h0
`define RANGE_RSVD 3'h4
`define RANGE_PDOWN 3'h7
`define MASK_RESET 8'h00
`define CFG_RESET 3'h0
`define FRAME_BITS 5'h10
`define MODE_MANUAL 1'b0
`define MODE_AUTO 1'b1
`endif

//--- rtl/link_sync.v
// Two-flop synchroniser for link pins
module link_sync #(
    // Reset to the pin's idle level so that no false edge follows reset
    parameter [0:0] RST_VAL = 1'b0
) (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Asynchronous level and its synchronised copy
    input wire din,
    output reg dout
);
    reg meta_r;
    always @(posedge clock) begin
        if (sys_rst) begin
            meta_r <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

//--- tb/seq_ctrl_props.sv
// Assertion checker for the channel sequencing control block
module seq_ctrl_props (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Link pin
    input wire cs_n,
    // Conversion control
    input wire [1:0] sample_ch_r,
    input wire sample_temp_r,
    input wire [2:0] sample_range_r,
    input wire power_down_r,
    input wire frame_start_r,
    input wire mode_r,
    input wire page_r,
    input wire [1:0] result_ch_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    frame_gap_a: assert property (frame_start_r |=> !frame_start_r [*8])
        else $error("frame pulses too close");
    ch_hold_a: assert property (!frame_start_r |-> $stable(sample_ch_r))
        else $error("channel moved between frames");
    result_lag_a: assert property (frame_start_r |-> result_ch_r == $past(sample_ch_r))
        else $error("result channel not one frame behind");
    mode_hold_a: assert property (!frame_start_r |-> $stable(mode_r))
        else $error("mode moved between frames");
    sel_hold_a: assert property (!frame_start_r |->
        $stable({sample_temp_r, sample_range_r}))
        else $error("range or sensor moved between frames");
    pdown_frame_a: assert property ($rose(power_down_r) |-> ##[1:20] frame_start_r)
        else $error("power-down not at end of frame");
    pdown_clear_a: assert property ($fell(power_down_r) |-> !cs_n)
        else $error("power-down cleared outside a frame");
    page_stay_a: assert property (!frame_start_r |-> $stable(page_r))
        else $error("page moved outside a frame end");
endmodule
bind seq_ctrl seq_ctrl_props u_props (.clock(clock), .sys_rst(sys_rst), .cs_n(cs_n),
    .sample_ch_r(sample_ch_r), .sample_temp_r(sample_temp_r), .sample_range_r(sample_range_r),
    .power_down_r(power_down_r), .frame_start_r(frame_start_r), .mode_r(mode_r),
    .page_r(page_r), .result_ch_r(result_ch_r));

//--- tb/host_master.sv
// Behavioural serial host that writes 16-bit frames
module host_master (
    // System clock for pacing
    input wire logic clock,
    // Serial link pins
    output logic sclk,
    output logic cs_n,
    output logic din
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b1;
    end
    task automatic half();
        repeat (4) @(posedge clock);
        #1;
    endtask
    // Address, write flag and data MSB first, sclk idle low between frames
    task automatic send(input logic [15:0] w);
        @(posedge clock);
        #1;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            din = w[i];
            half();
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        half();
        din = ~w[0];
        cs_n = 1'b1;
        half();
        half();
    endtask
endmodule

//--- tb/seq_ctrl_tb_top.sv
// Scoreboard testbench for the channel sequencing control block
`include "seq_ctrl_defines.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR %0t: got %b expected %b", $time, a, b); end end
module seq_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, sys_rst = 1, sclk, cs_n, din, sample_temp_r, power_down_r;
    logic frame_start_r, mode_r, page_r;
    logic [1:0] sample_ch_r, result_ch_r, ch;
    logic [2:0] sample_range_r, r;
    logic [2:0] rtab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    logic [2:0] cfg [4] = '{3'h0, 3'h2, 3'h0, 3'h0};
    logic [9:0] exp_q [$], e;
    logic [7:0] d;
    logic [2:0] pe = 3'h0;
    int n_errors = 0, samples_checked = 0, seed = 98788;
    initial forever #50 clock = ~clock;
    host_master u_host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .din(din));
    seq_ctrl u_seq_ctrl (.clock(clock), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
        .din(din), .sample_ch_r(sample_ch_r), .sample_temp_r(sample_temp_r),
        .sample_range_r(sample_range_r), .power_down_r(power_down_r),
        .frame_start_r(frame_start_r), .mode_r(mode_r), .page_r(page_r),
        .result_ch_r(result_ch_r));
    // Note fields: care, power-down, mode, sensor, channel, range
    function automatic logic [9:0] mk(input logic [1:0] c, input logic p, input logic m,
        input logic t, input logic [1:0] h, input logic [2:0] g);
        return {c, p, m, t, h, g};
    endfunction
    task automatic fr(input logic [6:0] a, input logic [7:0] d, input logic [9:0] n);
        exp_q.push_back(n);
        u_host.send({a, 1'b0, d});
    endtask
    task automatic conclude();
        $display("Checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(negedge clock) begin
        if (frame_start_r === 1'b1) begin
            `CHK(exp_q.size() != 0, 1'b1)
            e = exp_q.pop_front();
            `CHK(power_down_r, e[7])
            if (e[9]) `CHK({mode_r, sample_temp_r}, e[6:5])
            if (e[8]) `CHK({sample_ch_r, sample_range_r}, e[4:0])
            if (pe[2]) `CHK(result_ch_r, pe[1:0])
            pe = {e[8], e[4:3]};
        end
    end
    initial begin
        #2000000;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clock);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge clock);
        fr(`ADDR_CFG_BASE + 7'h01, 8'h02, 10'h000);
        fr(`ADDR_CH_MASK, 8'h2a, 10'h000);
        for (int k = 0; k < 8; k++) begin
            ch = 2'($random(seed));
            r = rtab[{$random(seed)} % 6];
            d = {1'b0, ch, 1'b1, r, 1'b0};
            fr(`ADDR_MANUAL, d, mk(3, 0, 0, 0, ch, r == 0 ? cfg[ch] : r));
        end
        fr(`ADDR_MANUAL, 8'h45, mk(2, 0, 0, 1, 0, 0));
        fr(7'h00, 8'h00, mk(2, 0, 0, 1, 0, 0));
        fr(`ADDR_AUTO, 8'h8a, mk(3, 0, 1, 0, 1, 5));
        fr(7'h00, 8'h00, mk(3, 0, 1, 0, 2, 0));
        fr(7'h00, 8'h00, mk(3, 0, 1, 0, 3, 0));
        fr(7'h00, 8'h00, mk(3, 0, 1, 0, 1, 2));
        fr(`ADDR_AUTO, 8'h01, mk(2, 0, 1, 1, 0, 0));
        fr(`ADDR_AUTO, 8'h00, mk(3, 0, 1, 0, 2, 0));
        fr(`ADDR_MANUAL, 8'h4e, mk(2, 1, 0, 0, 0, 0));
        fr(`ADDR_MANUAL, 8'h40, mk(3, 0, 0, 0, 2, 0));
        fr(`ADDR_PAGE, `PAGE1_VALUE, 10'h000);
        fr(`ADDR_MANUAL, 8'h60, mk(3, 0, 0, 0, 2, 0));
        repeat (20) @(posedge clock);
        `CHK(page_r, 1'b1)
        `CHK(exp_q.size() == 0, 1'b1)
        conclude();
    end
endmodule
